// *** hw/sfs_pkg.sv ***
// constants, types and register map of the servo forced stop sequencer
// Behaviour
// - forced stop two input off starts deceleration with the decel time constant
// - below zero speed during deceleration, cut base power and apply dynamic brake
// - show the forced stop warning code while the stop sequence runs
// - a host link break starts the same forced stop deceleration
// - no forced stop deceleration in torque control mode
// - deceleration follows an internally generated model speed command
// - lock interlock off first, base shut-off after the shut-off delay
// - freefall lift only when the compensation amount is nonzero
// - freefall lift only when the stop starts at or below zero speed
// - freefall lift needs the shut-off delay enabled; lifts by the amount
// - immediate dynamic brake alarms skip deceleration and brake at once
// - safe torque off dropping during deceleration raises the timing error alarm
// - alarm clears only by reset or reset command, and only without cause
// - deceleration enabled when stop function selection digit is 2, the default
// - a link break may brake directly, depending on how the link was lost
package sfs_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned MS_CYC        = MS_NS / CLK_PERIOD_NS;
   // full-scale speed used to scale the ramp, r/min
   localparam logic [31:0] RAMP_FULL_SPEED = 32'h0000_0BB8;

   // ****************************************
   // register map, byte addresses
   // ****************************************
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_DECEL_TC = 8'h04;
   localparam logic [7:0] ADDR_ZERO_SPD = 8'h08;
   localparam logic [7:0] ADDR_SHUT_DLY = 8'h0C;
   localparam logic [7:0] ADDR_FREEFALL = 8'h10;
   localparam logic [7:0] ADDR_CMD      = 8'h14;
   localparam logic [7:0] ADDR_STATUS   = 8'h18;
   localparam logic [7:0] ADDR_MODEL    = 8'h1C;

   localparam int unsigned CTRL_SEL_LSB    = 0;
   localparam int unsigned CTRL_TORQUE_BIT = 4;
   localparam int unsigned CMD_ERR_RST_BIT = 0;
   localparam int unsigned CMD_CPU_RST_BIT = 1;
   localparam int unsigned ST_ALARM_BIT    = 4;
   localparam int unsigned ST_BASE_BIT     = 5;
   localparam int unsigned ST_DB_BIT       = 6;
   localparam int unsigned ST_LOCK_BIT     = 7;
   localparam int unsigned ST_LIFT_BIT     = 8;
   localparam int unsigned ST_DISP_LSB     = 16;

   localparam logic [3:0]  RST_STOP_SEL  = 4'h2;
   localparam logic [3:0]  SEL_DECEL_ON  = 4'h2;
   localparam logic [15:0] RST_DECEL_TC  = 16'h0064;
   localparam logic [15:0] RST_ZERO_SPD  = 16'h0032;
   localparam logic [15:0] RST_SHUT_DLY  = 16'h0000;
   localparam logic [15:0] RST_FREEFALL  = 16'h0000;

   localparam logic [7:0] CODE_NONE    = 8'h00;
   localparam logic [7:0] CODE_WARN_E6 = 8'hE6;
   localparam logic [7:0] CODE_STO_ERR = 8'h63;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [3:0] {
      ST_RUN   = 4'h1,
      ST_DECEL = 4'h2,
      ST_DELAY = 4'h4,
      ST_STOP  = 4'h8
   } sfs_state_type;

   typedef struct packed {
      logic [3:0]  stop_sel;
      logic        torque_mode;
      logic [15:0] decel_tc;
      logic [15:0] zero_speed;
      logic [15:0] shutoff_dly;
      logic [15:0] freefall;
   } sfs_cfg_type;

   typedef struct packed {
      logic        base_on;
      logic        dyn_brake;
      logic        lock_on;
      logic        lift;
   } sfs_drive_type;

endpackage : sfs_pkg

// *** hw/sfs_sync.sv ***
// two flip-flop synchroniser for pin inputs
module sfs_sync #(
   parameter int unsigned W = 2
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second; pins idle high (no stop)
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '1;
         q      <= '1;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : sfs_sync

// *** hw/sfs_top.sv ***
// servo forced stop sequencer with its axi4-lite register file
//
// Design decisions made here: the AXI4-Lite register port and the address map.
module sfs_top #(
   parameter int unsigned MS_CYCLES = sfs_pkg::MS_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   output logic [1:0]       s_bresp,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   input  wire logic [7:0]  s_araddr,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   input  wire logic        forced_stop_two_input,
   input  wire logic        safe_torque_off_input,
   input  wire logic        link_ok,
   input  wire logic        link_loss_dyn_brake,
   input  wire logic        alarm_in,
   input  wire logic        alarm_dyn_brake,
   input  wire logic [7:0]  alarm_code_in,
   input  wire logic [15:0] motor_speed,
   input  wire logic [15:0] host_speed_cmd,
   output logic             base_on,
   output logic             dyn_brake,
   output logic             lock_interlock_output,
   output logic             freefall_lift,
   output logic [15:0]      lift_amount,
   output logic [15:0]      speed_cmd_out,
   output logic [7:0]       display_code,
   output logic             alarm_active
);

   // ****************************************
   // declarations
   // ****************************************
   sfs_pkg::sfs_cfg_type   cfg_r;
   sfs_pkg::sfs_state_type st_r;
   sfs_pkg::sfs_drive_type drv_r;
   logic [1:0]  pins_s;
   logic        em2_on;
   logic        sto_on;
   logic        aw_got_r;
   logic        w_got_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        wr_fire;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        clr_cmd;
   logic        alarm_r;
   logic [7:0]  alarm_code_r;
   logic        cause;
   logic        sto_err;
   logic        imm_db;
   logic        comm_break;
   logic        stop_req;
   logic        decel_ok;
   logic        below_zero;
   logic        ff_en;
   logic        src_em2_r;
   logic [31:0] ms_cnt_r;
   logic        ms_tick;
   logic [15:0] dly_cnt_r;
   logic [15:0] model_r;
   logic [31:0] acc_r;
   logic [7:0]  disp_r;
   logic [31:0] rd_word;
   logic [31:0] wr_old;
   logic [31:0] wr_new;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] sfs_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : sfs_merge

   function automatic logic sfs_mapped(input logic [7:0] a);
      return (a[7:5] == 3'h0);
   endfunction : sfs_mapped

   // ****************************************
   // pin synchronisers
   // ****************************************
   sfs_sync #(
      .W (2)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({forced_stop_two_input, safe_torque_off_input}),
      .q   (pins_s)
   );

   assign em2_on = pins_s[1];
   assign sto_on = pins_s[0];

   // ****************************************
   // axi4-lite write channel
   // ****************************************
   assign s_awready = !aw_got_r && !bvalid_r;
   assign s_wready  = !w_got_r && !bvalid_r;
   assign wr_fire   = aw_got_r && w_got_r && !bvalid_r;
   assign s_bvalid  = bvalid_r;
   assign s_bresp   = bresp_r;

   // address and data may arrive in either order
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r  <= sfs_pkg::RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_wdata;
            wstrb_r <= s_wstrb;
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r  <= sfs_mapped(awaddr_r) ? sfs_pkg::RESP_OKAY : sfs_pkg::RESP_SLVERR;
         end else if (bvalid_r && s_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_r.stop_sel    <= sfs_pkg::RST_STOP_SEL;
         cfg_r.torque_mode <= 1'b0;
         cfg_r.decel_tc    <= sfs_pkg::RST_DECEL_TC;
         cfg_r.zero_speed  <= sfs_pkg::RST_ZERO_SPD;
         cfg_r.shutoff_dly <= sfs_pkg::RST_SHUT_DLY;
         cfg_r.freefall    <= sfs_pkg::RST_FREEFALL;
      end else if (wr_fire) begin
         case (awaddr_r[7:2])
            sfs_pkg::ADDR_CTRL[7:2]: begin
               cfg_r.stop_sel    <= wr_new[3:0];
               cfg_r.torque_mode <= wr_new[sfs_pkg::CTRL_TORQUE_BIT];
            end
            sfs_pkg::ADDR_DECEL_TC[7:2]:
               cfg_r.decel_tc <= wr_new[15:0];
            sfs_pkg::ADDR_ZERO_SPD[7:2]:
               cfg_r.zero_speed <= wr_new[15:0];
            sfs_pkg::ADDR_SHUT_DLY[7:2]:
               cfg_r.shutoff_dly <= wr_new[15:0];
            sfs_pkg::ADDR_FREEFALL[7:2]:
               cfg_r.freefall <= wr_new[15:0];
            default: begin
            end
         endcase
      end
   end

   // old contents of the addressed register, so unstrobed lanes keep their bytes
   always_comb begin
      wr_old = 32'h0000_0000;
      case (awaddr_r[7:2])
         sfs_pkg::ADDR_CTRL[7:2]:     wr_old = {27'h0, cfg_r.torque_mode, cfg_r.stop_sel};
         sfs_pkg::ADDR_DECEL_TC[7:2]: wr_old = {16'h0000, cfg_r.decel_tc};
         sfs_pkg::ADDR_ZERO_SPD[7:2]: wr_old = {16'h0000, cfg_r.zero_speed};
         sfs_pkg::ADDR_SHUT_DLY[7:2]: wr_old = {16'h0000, cfg_r.shutoff_dly};
         sfs_pkg::ADDR_FREEFALL[7:2]: wr_old = {16'h0000, cfg_r.freefall};
         default:                     wr_old = 32'h0000_0000;
      endcase
   end

   assign wr_new = sfs_merge(wr_old, wdata_r, wstrb_r);

   // reset commands only act through byte lane 0
   assign clr_cmd = wr_fire && (awaddr_r[7:2] == sfs_pkg::ADDR_CMD[7:2]) && wstrb_r[0]
                    && (wdata_r[sfs_pkg::CMD_ERR_RST_BIT] || wdata_r[sfs_pkg::CMD_CPU_RST_BIT]);

   // ****************************************
   // axi4-lite read channel
   // ****************************************
   always_comb begin
      rd_word = 32'h0000_0000;
      case (s_araddr[7:2])
         sfs_pkg::ADDR_CTRL[7:2]: begin
            rd_word[3:0]                     = cfg_r.stop_sel;
            rd_word[sfs_pkg::CTRL_TORQUE_BIT] = cfg_r.torque_mode;
         end
         sfs_pkg::ADDR_DECEL_TC[7:2]: rd_word[15:0] = cfg_r.decel_tc;
         sfs_pkg::ADDR_ZERO_SPD[7:2]: rd_word[15:0] = cfg_r.zero_speed;
         sfs_pkg::ADDR_SHUT_DLY[7:2]: rd_word[15:0] = cfg_r.shutoff_dly;
         sfs_pkg::ADDR_FREEFALL[7:2]: rd_word[15:0] = cfg_r.freefall;
         sfs_pkg::ADDR_STATUS[7:2]: begin
            rd_word[3:0]                   = st_r;
            rd_word[sfs_pkg::ST_ALARM_BIT] = alarm_r;
            rd_word[sfs_pkg::ST_BASE_BIT]  = drv_r.base_on;
            rd_word[sfs_pkg::ST_DB_BIT]    = drv_r.dyn_brake;
            rd_word[sfs_pkg::ST_LOCK_BIT]  = drv_r.lock_on;
            rd_word[sfs_pkg::ST_LIFT_BIT]  = drv_r.lift;
            rd_word[sfs_pkg::ST_DISP_LSB +: 8] = disp_r;
         end
         sfs_pkg::ADDR_MODEL[7:2]: rd_word[15:0] = model_r;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   assign s_arready = !rvalid_r;
   assign s_rvalid  = rvalid_r;
   assign s_rdata   = rdata_r;
   assign s_rresp   = rresp_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= sfs_pkg::RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_word;
         rresp_r  <= sfs_mapped(s_araddr) ? sfs_pkg::RESP_OKAY : sfs_pkg::RESP_SLVERR;
      end else if (rvalid_r && s_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ****************************************
   // alarm latch
   // ****************************************
   assign sto_err = (st_r == sfs_pkg::ST_DECEL) && !sto_on;
   assign cause   = alarm_in || sto_err
                    || (alarm_code_r == sfs_pkg::CODE_STO_ERR && !sto_on);

   // a new alarm wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         alarm_r      <= 1'b0;
         alarm_code_r <= sfs_pkg::CODE_NONE;
      end else if (sto_err) begin
         alarm_r      <= 1'b1;
         alarm_code_r <= sfs_pkg::CODE_STO_ERR;
      end else if (alarm_in) begin
         alarm_r      <= 1'b1;
         alarm_code_r <= alarm_code_in;
      end else if (clr_cmd && !cause) begin
         alarm_r      <= 1'b0;
         alarm_code_r <= sfs_pkg::CODE_NONE;
      end
   end

   // ****************************************
   // stop decisions
   // ****************************************
   assign comm_break = !link_ok;
   assign stop_req   = !em2_on || comm_break || alarm_r || alarm_in;
   assign imm_db     = (alarm_in && alarm_dyn_brake) || sto_err
                       || (comm_break && link_loss_dyn_brake);
   assign decel_ok   = (cfg_r.stop_sel == sfs_pkg::SEL_DECEL_ON)
                       && !cfg_r.torque_mode;
   assign below_zero = motor_speed < cfg_r.zero_speed;
   assign ff_en      = (cfg_r.freefall != 16'h0000)
                       && (cfg_r.shutoff_dly != 16'h0000);

   // ****************************************
   // millisecond time base
   // ****************************************
   assign ms_tick = (ms_cnt_r == MS_CYCLES - 1);

   always_ff @(posedge clk) begin
      if (rst || ms_tick) begin
         ms_cnt_r <= 32'h0000_0000;
      end else begin
         ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r      <= sfs_pkg::ST_RUN;
         src_em2_r <= 1'b0;
      end else begin
         case (st_r)
            sfs_pkg::ST_RUN: begin
               src_em2_r <= !em2_on;
               if (stop_req) begin
                  if (imm_db || !decel_ok) begin
                     st_r <= sfs_pkg::ST_STOP;
                  end else if (motor_speed <= cfg_r.zero_speed) begin
                     st_r <= sfs_pkg::ST_DELAY;
                  end else begin
                     st_r <= sfs_pkg::ST_DECEL;
                  end
               end
            end
            sfs_pkg::ST_DECEL: begin
               if (imm_db) begin
                  st_r <= sfs_pkg::ST_STOP;
               end else if (below_zero) begin
                  st_r <= sfs_pkg::ST_DELAY;
               end
            end
            sfs_pkg::ST_DELAY: begin
               if (imm_db || dly_cnt_r >= cfg_r.shutoff_dly) begin
                  st_r <= sfs_pkg::ST_STOP;
               end
            end
            sfs_pkg::ST_STOP: begin
               if (!stop_req) begin
                  st_r <= sfs_pkg::ST_RUN;
               end
            end
            default: st_r <= sfs_pkg::ST_STOP;
         endcase
      end
   end

   // shut-off delay in whole milliseconds, jitter under one ms
   always_ff @(posedge clk) begin
      if (rst || st_r != sfs_pkg::ST_DELAY) begin
         dly_cnt_r <= 16'h0000;
      end else if (ms_tick && dly_cnt_r != 16'hFFFF) begin
         dly_cnt_r <= dly_cnt_r + 16'h0001;
      end
   end

   // ****************************************
   // model speed command ramp
   // ****************************************
   // error-accumulating ramp avoids a divider; one step per clock at most
   always_ff @(posedge clk) begin
      if (rst) begin
         model_r <= 16'h0000;
         acc_r   <= 32'h0000_0000;
      end else if (st_r != sfs_pkg::ST_DECEL) begin
         model_r <= motor_speed;
         acc_r   <= 32'h0000_0000;
      end else if (cfg_r.decel_tc == 16'h0000) begin
         model_r <= 16'h0000;
      end else if (ms_tick) begin
         acc_r <= acc_r + sfs_pkg::RAMP_FULL_SPEED;
      end else if (model_r != 16'h0000 && acc_r >= {16'h0000, cfg_r.decel_tc}) begin
         acc_r   <= acc_r - {16'h0000, cfg_r.decel_tc};
         model_r <= model_r - 16'h0001;
      end
   end

   // ****************************************
   // drive outputs
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         drv_r         <= '0;
         speed_cmd_out <= 16'h0000;
         lift_amount   <= 16'h0000;
      end else begin
         drv_r.base_on   <= st_r != sfs_pkg::ST_STOP;
         drv_r.dyn_brake <= st_r == sfs_pkg::ST_STOP;
         drv_r.lock_on   <= st_r == sfs_pkg::ST_RUN || st_r == sfs_pkg::ST_DECEL;
         if (st_r == sfs_pkg::ST_RUN) begin
            drv_r.lift <= stop_req && !imm_db && decel_ok && ff_en
                          && motor_speed <= cfg_r.zero_speed;
         end else if (st_r != sfs_pkg::ST_DELAY) begin
            drv_r.lift <= 1'b0;
         end
         lift_amount   <= ff_en ? cfg_r.freefall : 16'h0000;
         speed_cmd_out <= (st_r == sfs_pkg::ST_RUN) ? host_speed_cmd : model_r;
      end
   end

   // alarm codes take priority on the display
   always_ff @(posedge clk) begin
      if (rst) begin
         disp_r <= sfs_pkg::CODE_NONE;
      end else if (alarm_r) begin
         disp_r <= alarm_code_r;
      end else if (st_r != sfs_pkg::ST_RUN && src_em2_r) begin
         disp_r <= sfs_pkg::CODE_WARN_E6;
      end else begin
         disp_r <= sfs_pkg::CODE_NONE;
      end
   end

   assign base_on               = drv_r.base_on;
   assign dyn_brake             = drv_r.dyn_brake;
   assign lock_interlock_output = drv_r.lock_on;
   assign freefall_lift         = drv_r.lift;
   assign display_code          = disp_r;
   assign alarm_active          = alarm_r;

   // ****************************************
   // assertions
   // ****************************************
   AST_DECEL_POWERED: assert property (@(posedge clk) disable iff (rst)
      st_r == sfs_pkg::ST_DECEL |=> base_on && !dyn_brake)
      else $error("base lost during deceleration");
   AST_ZERO_EXIT: assert property (@(posedge clk) disable iff (rst)
      st_r == sfs_pkg::ST_DECEL && below_zero && !imm_db |=> st_r == sfs_pkg::ST_DELAY)
      else $error("deceleration did not end below zero speed");
   AST_WARN_SHOWN: assert property (@(posedge clk) disable iff (rst)
      st_r == sfs_pkg::ST_DECEL && src_em2_r && !alarm_r |=> display_code == 8'hE6)
      else $error("warning code missing");
   AST_COMM_DECEL: assert property (@(posedge clk) disable iff (rst)
      st_r == sfs_pkg::ST_RUN && !link_ok && !link_loss_dyn_brake && !alarm_in
      && decel_ok && motor_speed > cfg_r.zero_speed |=> st_r == sfs_pkg::ST_DECEL)
      else $error("link break did not decelerate");
   AST_TORQUE_MODE: assert property (@(posedge clk) disable iff (rst)
      st_r == sfs_pkg::ST_RUN && stop_req && cfg_r.torque_mode |=> st_r == sfs_pkg::ST_STOP)
      else $error("decelerated in torque mode");
   AST_MODEL_CMD: assert property (@(posedge clk) disable iff (rst)
      st_r == sfs_pkg::ST_DECEL |=> speed_cmd_out == $past(model_r))
      else $error("speed command not from model");
   AST_LOCK_FIRST: assert property (@(posedge clk) disable iff (rst)
      st_r == sfs_pkg::ST_DELAY |=> !lock_interlock_output && base_on)
      else $error("lock or base order wrong");
   AST_LIFT_AMOUNT: assert property (@(posedge clk) disable iff (rst)
      freefall_lift |-> lift_amount != 16'h0000 && cfg_r.shutoff_dly != 16'h0000)
      else $error("lift without amount or delay");
   AST_IMM_BRAKE: assert property (@(posedge clk) disable iff (rst)
      alarm_in && alarm_dyn_brake && st_r != sfs_pkg::ST_STOP ##1 1'b1
      |=> dyn_brake && !base_on)
      else $error("immediate brake alarm not braked");
   AST_STO_ERR: assert property (@(posedge clk) disable iff (rst)
      st_r == sfs_pkg::ST_DECEL && !sto_on |=> alarm_active && alarm_code_r == 8'h63)
      else $error("torque off timing error not raised");
   AST_CLEAR_GUARD: assert property (@(posedge clk) disable iff (rst)
      alarm_r && (alarm_in || !clr_cmd) |=> alarm_active)
      else $error("alarm cleared while cause present");
   AST_DISABLED_STOP: assert property (@(posedge clk) disable iff (rst)
      st_r == sfs_pkg::ST_RUN && stop_req && !decel_ok |=> ##1 dyn_brake)
      else $error("no immediate brake with deceleration off");

endmodule : sfs_top

// *** test/sfs_host_model.sv ***
// host controller model: link state and speed command
module sfs_host_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        drop,
   input  wire logic        brake_mode,
   output logic             link_ok,
   output logic             link_loss_dyn_brake,
   output logic [15:0]      host_speed_cmd
);
   timeunit 1ns;
   timeprecision 1ns;
   // link only changes on a clock edge, as a real receiver reports it
   always_ff @(posedge clk) begin
      link_ok             <= rst | ~drop;
      link_loss_dyn_brake <= ~rst & drop & brake_mode;
   end
   // fixed command so a pass-through is told apart from the model ramp
   assign host_speed_cmd = 16'h1234;
endmodule : sfs_host_model

// *** test/tb_top.sv ***
// bench for the forced stop sequencer
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk=0, rst=1, s_awvalid=0, s_wvalid=0, s_bready=0, s_arvalid=0, s_rready=0;
   logic forced_stop_two_input=1, safe_torque_off_input=1, alarm_in=0, alarm_dyn_brake=0;
   logic [7:0] s_awaddr=0, s_araddr=0, alarm_code_in=0, display_code;
   logic [31:0] s_wdata=0, s_rdata, rd;
   logic [3:0] s_wstrb=4'hF;
   logic [15:0] motor_speed=0, host_speed_cmd, lift_amount, speed_cmd_out;
   logic [1:0] s_bresp, s_rresp, rr;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, link_ok, link_loss_dyn_brake;
   logic base_on, dyn_brake, lock_interlock_output, freefall_lift, alarm_active, drop=0, dbm=0;
   int n_mismatch=0, total_checks=0, cyc=0;
   sfs_top #(.MS_CYCLES(20)) sfs_top_inst (.*);
   sfs_host_model sfs_host_model_inst (.clk(clk), .rst(rst), .drop(drop), .brake_mode(dbm),
      .link_ok(link_ok), .link_loss_dyn_brake(link_loss_dyn_brake),
      .host_speed_cmd(host_speed_cmd));
   always #25 clk = ~clk;
   // ****************************************
   // tasks
   // ****************************************
   task print_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // ready is combinational, so it is sampled on the falling edge before the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic pa, pw, ka, kw, b;
      pa = 1; pw = 1;
      s_awaddr <= a; s_wdata <= d; s_awvalid <= 1; s_wvalid <= 1; s_bready <= 1;
      do begin
         @(negedge clk); b = s_bvalid; ka = pa && s_awready; kw = pw && s_wready;
         @(posedge clk);
         if (ka) begin pa = 0; s_awvalid <= 0; end
         if (kw) begin pw = 0; s_wvalid <= 0; end
      end while (!b);
      s_bready <= 0;
      @(posedge clk);
   endtask : wr
   task automatic rdt(input logic [7:0] a);
      logic p, k, b;
      p = 1;
      s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
      do begin
         @(negedge clk); b = s_rvalid; rd = s_rdata; rr = s_rresp; k = p && s_arready;
         @(posedge clk);
         if (k) begin p = 0; s_arvalid <= 0; end
      end while (!b);
      s_rready <= 0;
      @(posedge clk);
   endtask : rdt
   task automatic poll(input logic [3:0] x);
      int i;
      for (i = 0; i < 40; i++) begin
         rdt(sfs_pkg::ADDR_STATUS);
         if (rd[3:0] === x) break;
      end
      chk("state", rd[3:0], x);
   endtask : poll
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin n_mismatch++; print_verdict; end
   end
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rdt(sfs_pkg::ADDR_CTRL); chk("ctrl", rd, 32'h2);
      rdt(8'h20); chk("resp", rr, sfs_pkg::RESP_SLVERR);
      motor_speed <= 16'd1000; forced_stop_two_input <= 0;
      poll(4'h2);
      rdt(sfs_pkg::ADDR_STATUS);
      chk("disp", rd[23:16], sfs_pkg::CODE_WARN_E6);
      chk("model", speed_cmd_out <= 16'd1000 && speed_cmd_out != host_speed_cmd, 1);
      motor_speed <= 16'd10;
      poll(4'h8);
      chk("drive", {base_on, dyn_brake, lock_interlock_output}, 3'b010);
      forced_stop_two_input <= 1; motor_speed <= 16'd1000;
      poll(4'h1);
      drop <= 1;
      poll(4'h2);
      // a started stop runs to its end, so the motor must reach zero speed
      drop <= 0; motor_speed <= 16'd10; poll(4'h1);
      motor_speed <= 16'd1000; dbm <= 1; drop <= 1;
      poll(4'h8);
      drop <= 0; dbm <= 0; poll(4'h1);
      wr(sfs_pkg::ADDR_CTRL, 32'h12); forced_stop_two_input <= 0;
      poll(4'h8);
      forced_stop_two_input <= 1; wr(sfs_pkg::ADDR_CTRL, 32'h2); poll(4'h1);
      alarm_code_in <= 8'h37; alarm_in <= 1; alarm_dyn_brake <= 1;
      poll(4'h8);
      chk("code", display_code, 8'h37);
      wr(sfs_pkg::ADDR_CMD, 32'h1);
      chk("held", alarm_active, 1);
      alarm_in <= 0; alarm_dyn_brake <= 0;
      wr(sfs_pkg::ADDR_CMD, 32'h1);
      poll(4'h1);
      chk("alarm", alarm_active, 0);
      forced_stop_two_input <= 0; poll(4'h2);
      safe_torque_off_input <= 0;
      poll(4'h8);
      chk("sto", {alarm_active, display_code}, 9'h163);
      // the synchronised pin must settle before the clear is judged
      safe_torque_off_input <= 1; forced_stop_two_input <= 1;
      repeat (3) @(posedge clk);
      wr(sfs_pkg::ADDR_CMD, 32'h2);
      poll(4'h1);
      wr(sfs_pkg::ADDR_FREEFALL, 32'h7); wr(sfs_pkg::ADDR_SHUT_DLY, 32'h3);
      motor_speed <= 16'd10; forced_stop_two_input <= 0;
      poll(4'h4);
      chk("lift", {freefall_lift, lift_amount}, 17'h10007);
      chk("lock", {lock_interlock_output, base_on}, 2'b01);
      poll(4'h8);
      print_verdict;
   end
endmodule : tb_top
